// ---- design/qdc_decoder.sv ----
// Purpose: serial command decode and channel registers of a quad converter
// Assumes: link data sampled on falling link clock edges, APB slave on clk
// Notes: frames cross to clk by a toggle; channel state readable over APB
//
// Decided for this implementation: the APB register port and the placing of the registers.

// Operation
// - three-wire write-only link: sync, clock, data
// - frame: load control, channel pick, payload
// - load 01 copies input into DAC register
// - load 10 writes input and DAC registers
// - load 11 broadcasts store, move or both
// - load 11 select 11 is power-down only
// - power-down picks 1k, 100k or floating
// - reset clears registers, outputs zero scale
module qdc_decoder (
  input wire logic clk,
  input wire logic reset,
  input wire logic [qdc_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic linkClk,
  input wire logic syncN,
  input wire logic serialIn,
  output qdc_pkg::qdc_chan_t [qdc_pkg::CHAN_N-1:0] chanOut
);
  import qdc_pkg::*;

  // link domain
  logic [4:0] bitCnt_q;
  logic [FRAME_BITS-2:0] shift_q;
  qdc_frame_t frame_q;
  logic frameTgl_q;

  // clk domain
  logic tglMeta_q;
  logic tglSync_q;
  logic tglSeen_q;
  logic newFrame;
  logic cmdValid_q;
  qdc_frame_t cmd_q;
  logic [1:0] cmdLd;
  logic [1:0] cmdSel;
  logic ctrlEn_q;
  logic softClr;
  logic [15:0] frameCnt_q;
  logic [15:0] dropCnt_q;
  logic [DATA_W-1:0] inputReg_q [CHAN_N];
  logic [CHAN_N-1:0][DATA_W-1:0] dacReg_q;
  logic [CHAN_N-1:0][DATA_W-1:0] inputFlat;
  logic [CHAN_N-1:0] pdOn_q;
  logic [CHAN_N-1:0][1:0] pdMode_q;
  logic apbWrite;
  logic apbSetup;
  logic [31:0] rdData_d;
  logic rdErr_d;

  // per-channel action of a frame: {write input, write dac, move input to dac}
  function automatic logic [2:0] chanAction(input qdc_frame_t f, input logic [1:0] c);
    logic [1:0] ld;
    logic [1:0] sel;
    logic [2:0] act;
    ld = {f.loadCtrlHi, f.loadCtrlLo};
    sel = {f.chanPickHi, f.chanPickLo};
    act = 3'h0;
    if (ld != LD_ALL) begin
      if (sel == c) begin
        case (ld)
          LD_STORE: act = 3'h4;
          LD_MOVE: act = 3'h1;
          LD_BOTH: act = 3'h6;
          default: act = 3'h0;
        endcase
      end
    end else begin
      case (sel)
        ALL_STORE: act = 3'h4;
        ALL_MOVE: act = 3'h1;
        ALL_BOTH: act = 3'h6;
        default: act = 3'h0;
      endcase
    end
    return act;
  endfunction : chanAction

  // true when the frame powers down channel c
  function automatic logic pdHit(input qdc_frame_t f, input logic [1:0] c);
    logic cmd;
    cmd = {f.loadCtrlHi, f.loadCtrlLo} == LD_ALL && {f.chanPickHi, f.chanPickLo} == ALL_PWRDN;
    return cmd && (f.payload[PD_ALL_BIT] || f.payload[PD_CHAN_LSB +: 2] == c);
  endfunction : pdHit

  // both hi-z codes fold onto one load
  function automatic logic [1:0] pdMap(input logic [1:0] m);
    return (m == PD_HIZ_ALT) ? PD_HIZ : m;
  endfunction : pdMap

  // ---------------- link domain ----------------

  // bit counter restarts whenever sync is high between frames
  always_ff @(negedge linkClk or posedge syncN or posedge reset) begin
    if (reset || syncN) begin
      bitCnt_q <= 5'h00;
    end else if (bitCnt_q != FRAME_DONE) begin
      bitCnt_q <= bitCnt_q + 5'h01;
    end
  end

  // shift MSB first; bits past the sixteenth are ignored
  always_ff @(negedge linkClk or posedge reset) begin
    if (reset) begin
      shift_q <= '0;
    end else if (!syncN && bitCnt_q < FRAME_LAST) begin
      shift_q <= {shift_q[FRAME_BITS-3:0], serialIn};
    end
  end

  // whole frame held stable until the next one completes
  always_ff @(negedge linkClk or posedge reset) begin
    if (reset) begin
      frame_q <= '0;
      frameTgl_q <= 1'b0;
    end else if (!syncN && bitCnt_q == FRAME_LAST) begin
      frame_q <= {shift_q, serialIn};
      frameTgl_q <= ~frameTgl_q;
    end
  end

  frame_len_a: assert property (@(negedge linkClk) disable iff (reset)
    $changed(frameTgl_q) |-> $past(bitCnt_q) == FRAME_LAST && !$past(syncN))
    else $error("frame accepted without sixteen bits");

  frame_start_a: assert property (@(negedge syncN) disable iff (reset)
    bitCnt_q == 5'h00)
    else $error("frame started with a stale bit count");

  // ---------------- clk domain ----------------

  // toggle crossing; frame_q is stable long before the edge is seen
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tglMeta_q <= 1'b0;
      tglSync_q <= 1'b0;
      tglSeen_q <= 1'b0;
    end else begin
      tglMeta_q <= frameTgl_q;
      tglSync_q <= tglMeta_q;
      tglSeen_q <= tglSync_q;
    end
  end

  assign newFrame = tglSync_q ^ tglSeen_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmdValid_q <= 1'b0;
      cmd_q <= '0;
    end else begin
      cmdValid_q <= newFrame && ctrlEn_q;
      if (newFrame) begin
        cmd_q <= frame_q;
      end
    end
  end

  assign cmdLd = {cmd_q.loadCtrlHi, cmd_q.loadCtrlLo};
  assign cmdSel = {cmd_q.chanPickHi, cmd_q.chanPickLo};

  cross_take_a: assert property (@(posedge clk) disable iff (reset)
    newFrame && ctrlEn_q |=> cmdValid_q && cmd_q == $past(frame_q))
    else $error("completed frame not taken");

  cmd_drop_a: assert property (@(posedge clk) disable iff (reset)
    newFrame && !ctrlEn_q |=> !cmdValid_q)
    else $error("frame acted on while disabled");

  // channel registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int c = 0; c < CHAN_N; c++) begin
        inputReg_q[c] <= '0;
        dacReg_q[c] <= '0;
        pdOn_q[c] <= 1'b0;
        pdMode_q[c] <= PD_HIZ;
      end
    end else if (softClr) begin
      for (int c = 0; c < CHAN_N; c++) begin
        inputReg_q[c] <= '0;
        dacReg_q[c] <= '0;
        pdOn_q[c] <= 1'b0;
        pdMode_q[c] <= PD_HIZ;
      end
    end else if (cmdValid_q) begin
      for (int c = 0; c < CHAN_N; c++) begin
        if (chanAction(cmd_q, 2'(c))[2]) begin
          inputReg_q[c] <= cmd_q.payload;
        end
        if (chanAction(cmd_q, 2'(c))[1]) begin
          dacReg_q[c] <= cmd_q.payload;
          pdOn_q[c] <= 1'b0;
        end else if (chanAction(cmd_q, 2'(c))[0]) begin
          dacReg_q[c] <= inputReg_q[c];
          pdOn_q[c] <= 1'b0;
        end
        if (pdHit(cmd_q, 2'(c))) begin
          pdOn_q[c] <= 1'b1;
          pdMode_q[c] <= pdMap(cmd_q.payload[PD_MODE_LSB +: 2]);
        end
      end
    end
  end

  always_comb begin
    for (int c = 0; c < CHAN_N; c++) begin
      inputFlat[c] = inputReg_q[c];
      chanOut[c].powerDownCmd = pdOn_q[c];
      chanOut[c].pdLoad = pdMode_q[c];
      // a powered-down channel shows zero code
      chanOut[c].code = pdOn_q[c] ? '0 : dacReg_q[c];
    end
  end

  chan_map_a: assert property (@(posedge clk) disable iff (reset)
    cmdValid_q && cmdLd == LD_STORE && cmdSel == 2'h2 |=>
      inputFlat[2] == $past(cmd_q.payload) && inputFlat[0] == $past(inputFlat[0]))
    else $error("channel select code 10 did not address channel C");

  store_only_a: assert property (@(posedge clk) disable iff (reset)
    cmdValid_q && cmdLd == LD_STORE |=>
      dacReg_q == $past(dacReg_q) && inputFlat[$past(cmdSel)] == $past(cmd_q.payload))
    else $error("store changed a DAC register or missed the input register");

  move_copy_a: assert property (@(posedge clk) disable iff (reset)
    cmdValid_q && cmdLd == LD_MOVE |=>
      dacReg_q[$past(cmdSel)] == $past(inputFlat[cmdSel]) && inputFlat == $past(inputFlat))
    else $error("move did not copy the input register");

  write_both_a: assert property (@(posedge clk) disable iff (reset)
    cmdValid_q && cmdLd == LD_BOTH |=>
      dacReg_q[$past(cmdSel)] == $past(cmd_q.payload)
      && inputFlat[$past(cmdSel)] == $past(cmd_q.payload))
    else $error("store and update missed a register");

  broadcast_a: assert property (@(posedge clk) disable iff (reset)
    (cmdValid_q && cmdLd == LD_ALL && cmdSel == ALL_STORE |=>
      inputFlat == {CHAN_N{$past(cmd_q.payload)}} && dacReg_q == $past(dacReg_q))
    and (cmdValid_q && cmdLd == LD_ALL && cmdSel == ALL_MOVE |=>
      dacReg_q == $past(inputFlat))
    and (cmdValid_q && cmdLd == LD_ALL && cmdSel == ALL_BOTH |=>
      dacReg_q == {CHAN_N{$past(cmd_q.payload)}}))
    else $error("broadcast did not reach every channel");

  pd_no_load_a: assert property (@(posedge clk) disable iff (reset)
    cmdValid_q && cmdLd == LD_ALL && cmdSel == ALL_PWRDN |=>
      inputFlat == $past(inputFlat) && dacReg_q == $past(dacReg_q))
    else $error("power-down frame loaded data");

  pd_mode_a: assert property (@(posedge clk) disable iff (reset)
    cmdValid_q && cmdLd == LD_ALL && cmdSel == ALL_PWRDN && cmd_q.payload[PD_ALL_BIT] |=>
      pdOn_q == 4'hF && pdMode_q[3] == pdMap($past(cmd_q.payload[PD_MODE_LSB +: 2])))
    else $error("power-down load not applied to all channels");

  pd_single_a: assert property (@(posedge clk) disable iff (reset)
    cmdValid_q && cmdLd == LD_ALL && cmdSel == ALL_PWRDN && !cmd_q.payload[PD_ALL_BIT] |=>
      pdOn_q[$past(cmd_q.payload[PD_CHAN_LSB +: 2])]
      && pdMode_q[$past(cmd_q.payload[PD_CHAN_LSB +: 2])]
        == pdMap($past(cmd_q.payload[PD_MODE_LSB +: 2])))
    else $error("power-down load not applied to the picked channel");

  zero_reset_a: assert property (@(posedge clk) disable iff (reset)
    $fell(reset) || $past(softClr) |-> dacReg_q == '0 && inputFlat == '0 && pdOn_q == 4'h0)
    else $error("registers not cleared to zero scale");

  // ---------------- APB slave ----------------

  assign pready = 1'b1;
  assign apbSetup = psel && !penable;
  assign apbWrite = psel && penable && pwrite && !rdErr_d;
  assign softClr = apbWrite && paddr == CTRL_OFS && pwdata[CTRL_CLR_BIT];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrlEn_q <= CTRL_EN_RST;
    end else if (apbWrite && paddr == CTRL_OFS) begin
      ctrlEn_q <= pwdata[CTRL_EN_BIT];
    end
  end

  // accepted and dropped frame counts
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      frameCnt_q <= '0;
      dropCnt_q <= '0;
    end else if (newFrame) begin
      if (ctrlEn_q) begin
        frameCnt_q <= frameCnt_q + 16'h0001;
      end else begin
        dropCnt_q <= dropCnt_q + 16'h0001;
      end
    end
  end

  always_comb begin
    rdData_d = '0;
    rdErr_d = 1'b0;
    if (paddr[1:0] != 2'h0) begin
      rdErr_d = 1'b1;
    end else if (paddr == CTRL_OFS) begin
      rdData_d[CTRL_EN_BIT] = ctrlEn_q;
    end else if (paddr == STATUS_OFS) begin
      rdData_d = {dropCnt_q, frameCnt_q};
    end else if (paddr == LAST_OFS) begin
      rdData_d[FRAME_BITS-1:0] = cmd_q;
    end else if (paddr >= CHAN_OFS && paddr <= CHAN_END_OFS) begin
      rdData_d[DATA_W-1:0] = dacReg_q[paddr[3:2]];
      rdData_d[CHAN_IN_LSB +: DATA_W] = inputReg_q[paddr[3:2]];
      rdData_d[CHAN_PD_BIT] = pdOn_q[paddr[3:2]];
      rdData_d[CHAN_MODE_LSB +: 2] = pdMode_q[paddr[3:2]];
    end else begin
      rdErr_d = 1'b1;
    end
  end

  // read data and error captured in the setup cycle, shown in the access cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (apbSetup) begin
      prdata <= pwrite ? 32'h0000_0000 : rdData_d;
      pslverr <= rdErr_d;
    end else if (!psel) begin
      pslverr <= 1'b0;
    end
  end

  apb_ctrl_a: assert property (@(posedge clk) disable iff (reset)
    psel && penable && pwrite && paddr == CTRL_OFS |=> ctrlEn_q == $past(pwdata[CTRL_EN_BIT]))
    else $error("control write not stored");

endmodule : qdc_decoder

// ---- design/qdc_pkg.sv ----
// Purpose: shared constants and types for the quad converter command decoder
// Assumes: 16-bit write frames, MSB first, four channels of 12 bits
// Notes: APB register map and link frame layout live here
package qdc_pkg;

  localparam int DATA_W = 12;
  localparam int CHAN_N = 4;
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] FRAME_LAST = 5'h0F;
  localparam logic [4:0] FRAME_DONE = 5'h10;

  // load control codes
  localparam logic [1:0] LD_STORE = 2'h0;
  localparam logic [1:0] LD_MOVE = 2'h1;
  localparam logic [1:0] LD_BOTH = 2'h2;
  localparam logic [1:0] LD_ALL = 2'h3;

  // select codes while load control is LD_ALL
  localparam logic [1:0] ALL_STORE = 2'h0;
  localparam logic [1:0] ALL_MOVE = 2'h1;
  localparam logic [1:0] ALL_BOTH = 2'h2;
  localparam logic [1:0] ALL_PWRDN = 2'h3;

  // power-down payload fields and output loads
  localparam int PD_ALL_BIT = 11;
  localparam int PD_CHAN_LSB = 9;
  localparam int PD_MODE_LSB = 7;
  localparam logic [1:0] PD_HIZ = 2'h0;
  localparam logic [1:0] PD_1K = 2'h1;
  localparam logic [1:0] PD_100K = 2'h2;
  localparam logic [1:0] PD_HIZ_ALT = 2'h3;

  // APB map
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] LAST_OFS = 8'h08;
  localparam logic [7:0] CHAN_OFS = 8'h10;
  localparam logic [7:0] CHAN_END_OFS = 8'h1C;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int CHAN_IN_LSB = 16;
  localparam int CHAN_PD_BIT = 28;
  localparam int CHAN_MODE_LSB = 29;

  typedef struct packed {
    logic loadCtrlHi;
    logic loadCtrlLo;
    logic chanPickHi;
    logic chanPickLo;
    logic [DATA_W-1:0] payload;
  } qdc_frame_t;

  typedef struct packed {
    logic powerDownCmd;
    logic [1:0] pdLoad;
    logic [DATA_W-1:0] code;
  } qdc_chan_t;

endpackage : qdc_pkg

// ---- dv/qdc_host_model.sv ----
// Purpose: host controller model that shifts write frames into the decoder
// Assumes: link clock idles high, data changes on rising, sampled on falling
// Notes: clock stands still between frames; data line inverted 40 ns before sync is released
module qdc_host_model (
  output logic linkClk,
  output logic syncN,
  output logic serialIn
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    linkClk = 1'b1;
    syncN = 1'b1;
    serialIn = 1'b0;
  end

  // nbits below 16 gives an aborted frame
  task automatic send(input logic [15:0] frame, input int nbits);
    syncN = 1'b0;
    for (int i = 15; i >= 16 - nbits; i--) begin
      serialIn = frame[i];
      #80 linkClk = 1'b0;
      #80 linkClk = 1'b1;
    end
    #40 serialIn = ~serialIn;
    #40 syncN = 1'b1;
    #160;
  endtask : send
endmodule : qdc_host_model

// ---- dv/test_quad_dac_serial_command_decode.sv ----
// Purpose: self-checking bench for the quad converter command decoder
// Assumes: APB master on clk, host model on the link clock
// Notes: channel state checked at the ports and through APB reads
module test_quad_dac_serial_command_decode;
  timeunit 1ns;
  timeprecision 1ps;
  import qdc_pkg::*;

  logic clk, reset, psel, penable, pwrite, pready, pslverr;
  logic linkClk, syncN, serialIn;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic err;
  qdc_chan_t [CHAN_N-1:0] chanOut;
  int err_total = 0;
  int tests_run = 0;

  qdc_decoder DUT (.clk(clk), .reset(reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .linkClk(linkClk), .syncN(syncN),
    .serialIn(serialIn), .chanOut(chanOut));
  qdc_host_model host (.linkClk(linkClk), .syncN(syncN), .serialIn(serialIn));

  always #25 clk = ~clk;

  task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : checkWord

  task automatic checkChan(input int i, input logic pd, input logic [1:0] ld,
      input logic [11:0] code);
    qdc_chan_t exp;
    exp = '{powerDownCmd: pd, pdLoad: ld, code: code};
    tests_run++;
    if (chanOut[i] !== exp) begin
      err_total++;
      $display("mismatch at %0t: chan %0d got %h expected %h", $time, i, chanOut[i], exp);
    end
  endtask : checkChan

  task automatic frame(input logic [15:0] f, input int n);
    host.send(f, n);
    repeat (6) @(posedge clk);
  endtask : frame

  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  initial begin
    #400000;
    err_total++;
    tally_and_finish();
  end

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++) checkChan(i, 1'b0, 2'h0, 12'h000);
    apb(CTRL_OFS, 1'b0, 32'h0);
    checkWord(rd, 32'h0000_0001);
    checkWord({31'h0, pready}, 32'h1);
    frame(16'h1ABC, 16);
    checkChan(1, 1'b0, 2'h0, 12'h000);
    apb(8'h14, 1'b0, 32'h0);
    checkWord(rd, 32'h0ABC_0000);
    frame(16'h5123, 16);
    checkChan(1, 1'b0, 2'h0, 12'hABC);
    frame(16'hB5A5, 16);
    checkChan(3, 1'b0, 2'h0, 12'h5A5);
    checkChan(1, 1'b0, 2'h0, 12'hABC);
    frame(16'hC111, 16);
    for (int i = 0; i < 4; i++) checkChan(i, 1'b0, 2'h0, i == 1 ? 12'hABC : i == 3 ? 12'h5A5 : 12'h0);
    frame(16'hD000, 16);
    for (int i = 0; i < 4; i++) checkChan(i, 1'b0, 2'h0, 12'h111);
    frame(16'hE777, 16);
    for (int i = 0; i < 4; i++) checkChan(i, 1'b0, 2'h0, 12'h777);
    frame(16'hF480, 16);
    checkChan(2, 1'b1, 2'h1, 12'h000);
    checkChan(0, 1'b0, 2'h0, 12'h777);
    apb(8'h18, 1'b0, 32'h0);
    checkWord(rd & 32'h0FFF_0000, 32'h0777_0000);
    frame(16'hF900, 16);
    for (int i = 0; i < 4; i++) checkChan(i, 1'b1, 2'h2, 12'h000);
    frame(16'hF880, 16);
    for (int i = 0; i < 4; i++) checkChan(i, 1'b1, 2'h1, 12'h000);
    frame(16'hF000, 16);
    checkChan(0, 1'b1, 2'h0, 12'h000);
    frame(16'hD000, 16);
    checkChan(0, 1'b0, 2'h0, 12'h777);
    frame(16'h8321, 10);
    checkChan(0, 1'b0, 2'h0, 12'h777);
    apb(8'h40, 1'b0, 32'h0);
    checkWord({31'h0, err}, 32'h1);
    checkWord(rd, 32'h0);
    apb(CTRL_OFS, 1'b1, 32'h0);
    frame(16'h8321, 16);
    checkChan(0, 1'b0, 2'h0, 12'h777);
    apb(STATUS_OFS, 1'b0, 32'h0);
    checkWord({16'h0, rd[31:16]}, 32'h1);
    apb(CTRL_OFS, 1'b1, 32'h3);
    repeat (2) @(posedge clk);
    for (int i = 0; i < 4; i++) checkChan(i, 1'b0, 2'h0, 12'h000);
    frame(16'h8321, 16);
    checkChan(0, 1'b0, 2'h0, 12'h321);
    frame(16'h2456, 16);
    apb(8'h18, 1'b0, 32'h0);
    checkWord(rd, 32'h0456_0000);
    tally_and_finish();
  end
endmodule : test_quad_dac_serial_command_decode
